//--- core/dvc_debug_event.sv
// Debug event detection, vector catch, halt entry and exit, and debug registers.
// Assumes core event inputs are on ref_clk_i; outside halt and restart requests are asynchronous pins.
//
// Overview of operation
// - Catch enabled exception, halt at handler start.
// - Vector catch never raises monitor exception.
// - No instruction runs between cause and halt.
// - Late exceptions defer halt to final handler.
// - Exception entry sets fault cause bits.
// - Step, breakpoint, catch synchronous; others asynchronous.
// - Faulting fetch gives no breakpoint event.
// - Taken synchronous event suppresses instruction effects.
// - Step event taken on following instruction.
// - Only one synchronous event taken per instruction.
// - Undefined instruction makes no memory access.
// - Protection fault access raises no watchpoint.
// - Asynchronous events taken in bounded time.
// - Leave halt on halt clear or restart.
// - Reentry shows halt request and halted set.
// - Registers 32 bits; extension range reserved.
// - Writing one clears a status flag.
// - Only power-on reset clears status flags.
// - One status flag per event cause.
// - Fault cause kept while catch flag set; here fault_clear_i clears it regardless of the flag.
// - Halt or step request sets halt flag.
// - Stepped read of halt flag undefined.
`timescale 1ns/1ps
`default_nettype none

module dvc_debug_event (
  input  wire logic                ref_clk_i,
  input  wire logic                reset_i,
  input  wire logic                ce_i,
  input  wire logic                local_reset_i,
  input  wire logic                dbg_req_i,
  input  wire logic                dbg_write_i,
  input  wire logic [31:0]         dbg_addr_i,
  input  wire logic [31:0]         dbg_wdata_i,
  output logic                     dbg_ack_o,
  output logic [31:0]              dbg_rdata_o,
  input  wire logic                instr_valid_i,
  input  wire logic                instr_done_i,
  input  wire logic                breakpoint_event_flag_match_i,
  input  wire logic                fetch_fault_i,
  input  wire logic                undef_instr_i,
  input  wire logic                watch_match_i,
  input  wire logic                mpu_fault_i,
  input  wire logic                exc_taken_i,
  input  wire logic [2:0]          exc_vc_idx_i,
  input  wire logic                exc_fault_i,
  input  wire logic                handler_first_i,
  input  wire logic                prio_below_mon_i,
  input  wire logic [7:0]          fault_clear_i,
  input  wire logic                outside_halt_request_i,
  input  wire logic                outside_restart_i,
  output logic                     halted_o,
  output logic                     exec_allow_o,
  output logic                     mem_access_allow_o,
  output logic                     sync_suppress_o,
  output logic                     mon_exc_req_o,
  output logic                     mask_ints_o,
  output logic [7:0]               fault_cause_o,
  output logic [31:0]              core_reg_sel_o,
  output logic                     core_sel_wr_o,
  output logic [31:0]              core_reg_xfer_o
);
  import dvc_pkg::*;

  typedef struct packed {
    dvc_state_t             state;
    logic                   step_done;
    logic                   debug_en;
    logic                   halt;
    logic                   step;
    logic                   maskints;
    logic [VC_COUNT-1:0]    vc_en;
    logic                   mon_en;
    logic                   mon_pend;
    logic                   monitor_step_enable;
    logic [ST_WIDTH-1:0]    status;
    logic [7:0]             fault_cause;
    logic [31:0]            sel;
    logic                   sel_wr;
    logic [31:0]            xfer;
    logic [2:0]             ext_sync;
    logic                   ext_lvl;
    logic [2:0]             rst_sync;
    logic                   rst_lvl;
    logic                   ack;
    logic [31:0]            rdata;
  } dvc_regs_t;

  dvc_regs_t s;
  dvc_regs_t next_s;

  // Maps the catch index to its enable: index 0 is the low bit, 1 to 7 the upper field.
  function automatic logic vc_enabled(input logic [VC_COUNT-1:0] en, input logic [2:0] idx);
    vc_enabled = en[idx];
  endfunction

  function automatic logic is_addr(input logic [31:0] a, input logic [31:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  logic                wr;
  logic                hc_wr;
  logic                mon_wr;
  logic                st_wr;
  logic                running;
  logic                step_ev;
  logic                breakpoint_event_flag_ev;
  logic                vc_ev;
  logic                take_vc;
  logic                take_breakpoint_event_flag;
  logic                take_step;
  logic                breakpoint_event_flag_taken;
  logic                sync_take;
  logic                watch_ev;
  logic                ext_ev;
  logic                restart_ev;
  logic                halt_req_ev;
  logic                enter_halt;
  logic                arm_vc;
  logic                monitor_step_enable_set;
  logic [ST_WIDTH-1:0] st_set;
  logic [ST_WIDTH-1:0] st_clr;
  logic [31:0]         read_word;
  logic [7:0]          fault_set;

  assign wr     = dbg_req_i & dbg_write_i;
  // Key mismatch drops the whole halt control write.
  assign hc_wr  = wr & is_addr(dbg_addr_i, ADDR_HALT_CONTROL)
                  & (dbg_wdata_i[31:KEY_LSB] == WRITE_UNLOCK_KEY);
  assign mon_wr = wr & is_addr(dbg_addr_i, ADDR_MONITOR_CTL);
  assign st_wr  = wr & is_addr(dbg_addr_i, ADDR_EVENT_STATUS);

  assign running = (s.state != DVC_HALT);

  // Synchronous candidates; a faulting fetch never matches a breakpoint.
  assign step_ev = (s.state == DVC_STEP) & s.step_done & instr_valid_i;
  assign breakpoint_event_flag_ev = running & (s.state != DVC_CATCH) & instr_valid_i & breakpoint_event_flag_match_i & ~fetch_fault_i;
  assign vc_ev   = (s.state == DVC_CATCH) & handler_first_i;

  // A fixed order picks one event; any single choice is acceptable.
  assign take_vc    = vc_ev;
  assign take_breakpoint_event_flag  = breakpoint_event_flag_ev & ~vc_ev;
  assign take_step  = step_ev & ~vc_ev & ~breakpoint_event_flag_ev;
  assign breakpoint_event_flag_taken = take_breakpoint_event_flag & (s.debug_en | s.mon_en);
  assign sync_take  = take_vc | breakpoint_event_flag_taken | take_step;

  // Watchpoints are dropped for undefined instructions, protection faults and suppressed instructions.
  assign watch_ev = running & watch_match_i & ~mpu_fault_i & ~undef_instr_i & ~sync_take;
  assign ext_ev     = s.ext_sync[1] & s.ext_sync[2] & ~s.ext_lvl;
  assign restart_ev = s.rst_sync[1] & s.rst_sync[2] & ~s.rst_lvl;
  assign halt_req_ev = hc_wr & running & dbg_wdata_i[HC_DEBUG_EN] & dbg_wdata_i[HC_HALT];

  // Asynchronous events halt on the very next edge, which bounds their latency.
  assign enter_halt = running & ((s.debug_en & (take_vc | take_breakpoint_event_flag | take_step | watch_ev | ext_ev))
                                 | halt_req_ev);

  // Catch needs halting debug, the enable bit, the exception itself and either the cause bit or a fault on entry.
  assign arm_vc = running & s.debug_en & exc_taken_i & vc_enabled(s.vc_en, exc_vc_idx_i)
                  & (s.fault_cause[exc_vc_idx_i] | exc_fault_i);

  assign monitor_step_enable_set = mon_wr & dbg_wdata_i[MONITOR_STEP_ENABLE] & ~s.monitor_step_enable;

  assign fault_set = (exc_taken_i & exc_fault_i) ? (8'h01 << exc_vc_idx_i) : 8'h00;

  always_comb begin
    st_set = '0;
    st_set[ST_HALT]     = halt_req_ev | take_step | monitor_step_enable_set;
    st_set[ST_BREAKPOINT_EVENT_FLAG]     = breakpoint_event_flag_taken;
    st_set[ST_WATCH]    = watch_ev & (s.debug_en | s.mon_en);
    st_set[ST_VECTOR_CATCH_FLAG]   = take_vc;
    st_set[ST_EXTERNAL] = ext_ev & (s.debug_en | s.mon_en);
    st_clr = st_wr ? dbg_wdata_i[ST_WIDTH-1:0] : '0;
  end

  // Reserved and unmapped words read as zero; all registers are full words.
  always_comb begin
    read_word = 32'h0000_0000;
    if (is_addr(dbg_addr_i, ADDR_EVENT_STATUS)) begin
      read_word[ST_WIDTH-1:0] = s.status;
    end else if (is_addr(dbg_addr_i, ADDR_HALT_CONTROL)) begin
      read_word[HC_DEBUG_EN] = s.debug_en;
      read_word[HC_HALT]     = s.halt;
      read_word[HC_STEP]     = s.step;
      read_word[HC_MASKINTS] = s.maskints;
      read_word[HC_S_HALT]   = (s.state == DVC_HALT);
    end else if (is_addr(dbg_addr_i, ADDR_CORE_TRANSFER)) begin
      read_word = s.xfer;
    end else if (is_addr(dbg_addr_i, ADDR_MONITOR_CTL)) begin
      read_word[VC_LOW_BIT]                = s.vc_en[0];
      read_word[VC_FIELD_HI:VC_FIELD_LO]   = s.vc_en[VC_COUNT-1:1];
      read_word[MON_ENABLE]                = s.mon_en;
      read_word[MON_PEND]                  = s.mon_pend;
      read_word[MONITOR_STEP_ENABLE]                  = s.monitor_step_enable;
    end
  end

  always_comb begin
    next_s = s;
    next_s.ack    = dbg_req_i;
    next_s.rdata  = (dbg_req_i & ~dbg_write_i) ? read_word : 32'h0000_0000;
    next_s.sel_wr = 1'b0;

    // Only the second and third stages are compared, so a single glitch never counts.
    next_s.ext_sync = {s.ext_sync[1:0], outside_halt_request_i};
    next_s.rst_sync = {s.rst_sync[1:0], outside_restart_i};
    if (s.ext_sync[1] == s.ext_sync[2]) begin
      next_s.ext_lvl = s.ext_sync[2];
    end
    if (s.rst_sync[1] == s.rst_sync[2]) begin
      next_s.rst_lvl = s.rst_sync[2];
    end

    // Set wins over a simultaneous clear; writing zero keeps a flag.
    next_s.status      = (s.status & ~st_clr) | st_set;
    // The primary cause stays until the fault register owner clears it.
    next_s.fault_cause = (s.fault_cause & ~fault_clear_i) | fault_set;

    if (hc_wr) begin
      next_s.debug_en = dbg_wdata_i[HC_DEBUG_EN];
      next_s.halt     = dbg_wdata_i[HC_HALT];
      next_s.step     = dbg_wdata_i[HC_STEP];
      next_s.maskints = dbg_wdata_i[HC_MASKINTS];
    end
    if (mon_wr) begin
      next_s.vc_en    = {dbg_wdata_i[VC_FIELD_HI:VC_FIELD_LO], dbg_wdata_i[VC_LOW_BIT]};
      next_s.mon_en   = dbg_wdata_i[MON_ENABLE];
      next_s.mon_pend = dbg_wdata_i[MON_PEND];
      next_s.monitor_step_enable = dbg_wdata_i[MONITOR_STEP_ENABLE];
    end
    if (wr & is_addr(dbg_addr_i, ADDR_CORE_SELECTOR)) begin
      next_s.sel    = dbg_wdata_i;
      next_s.sel_wr = 1'b1;
    end
    if (wr & is_addr(dbg_addr_i, ADDR_CORE_TRANSFER)) begin
      next_s.xfer = dbg_wdata_i;
    end

    unique case (s.state)
      DVC_RUN, DVC_STEP, DVC_CATCH: begin
        if ((s.state == DVC_STEP) & instr_done_i) begin
          next_s.step_done = 1'b1;
        end
        if (enter_halt) begin
          // Hardware raises the halt request bit, so a read shows both halt bits on reentry.
          next_s.state = DVC_HALT;
          next_s.halt  = 1'b1;
        end else if (arm_vc) begin
          // A later exception during entry keeps the catch armed for the final handler.
          next_s.state = DVC_CATCH;
        end
      end
      DVC_HALT: begin
        if ((hc_wr & ~dbg_wdata_i[HC_HALT]) | restart_ev) begin
          next_s.halt      = 1'b0;
          next_s.step_done = 1'b0;
          next_s.state     = ((hc_wr ? dbg_wdata_i[HC_STEP] : s.step) & s.debug_en) ? DVC_STEP : DVC_RUN;
        end
      end
    endcase

    // A local reset restarts the core side but leaves the event status alone.
    if (local_reset_i) begin
      next_s.state     = DVC_RUN;
      next_s.step_done = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s          <= '0;
      s.state    <= DVC_RUN;
      s.status   <= STATUS_RESET;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign dbg_ack_o       = s.ack;
  assign dbg_rdata_o     = s.rdata;
  assign halted_o        = (s.state == DVC_HALT);
  // The stepped instruction simply sees the current flag; its value carries no promise.
  assign exec_allow_o    = instr_valid_i & running & ~sync_take;
  assign mem_access_allow_o = instr_valid_i & running & ~sync_take & ~undef_instr_i;
  assign sync_suppress_o = sync_take;
  // Vector catch is absent here on purpose: it only ever halts.
  assign mon_exc_req_o   = ~s.debug_en & s.mon_en & prio_below_mon_i & (take_breakpoint_event_flag | watch_ev | ext_ev);
  assign mask_ints_o     = s.debug_en & s.maskints;
  assign fault_cause_o   = s.fault_cause;
  assign core_reg_sel_o  = s.sel;
  assign core_sel_wr_o   = s.sel_wr;
  assign core_reg_xfer_o = s.xfer;

  default clocking dvc_cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_vc_halt_entry: assert property (
    (ce_i && s.state == DVC_CATCH && handler_first_i && !local_reset_i)
      |=> (halted_o && s.status[ST_VECTOR_CATCH_FLAG]))
    else $error("vector catch did not halt at the handler");

  chk_vc_no_monitor: assert property (
    (s.state == DVC_CATCH && handler_first_i) |-> !mon_exc_req_o)
    else $error("vector catch raised a monitor exception");

  chk_catch_blocks_exec: assert property (
    (s.state == DVC_CATCH && handler_first_i) |-> (!exec_allow_o && !mem_access_allow_o))
    else $error("instruction ran after a caught exception");

  chk_fetch_fault_breakpoint_event_flag: assert property (
    (s.state == DVC_RUN && fetch_fault_i) |-> !sync_suppress_o)
    else $error("faulting fetch produced a breakpoint event");

  chk_sync_suppress: assert property (
    sync_suppress_o |-> (!exec_allow_o && !mem_access_allow_o))
    else $error("suppressed instruction still executed");

  chk_undef_no_access: assert property (
    undef_instr_i |-> !mem_access_allow_o)
    else $error("undefined instruction allowed a memory access");

  chk_mpu_no_watch: assert property (
    (ce_i && mpu_fault_i && !st_wr) |=> (s.status[ST_WATCH] == $past(s.status[ST_WATCH])))
    else $error("protection fault raised a watchpoint flag");

  chk_async_halts: assert property (
    (ce_i && s.debug_en && watch_ev && !local_reset_i) |=> halted_o [*1] ##0 s.status[ST_WATCH])
    else $error("watchpoint did not halt on the next edge");

  chk_exit_on_clear: assert property (
    (ce_i && halted_o && hc_wr && !dbg_wdata_i[HC_HALT]) |=> !halted_o)
    else $error("halt clear did not leave debug state");

  chk_reentry_marks: assert property (
    $rose(halted_o) |-> s.halt)
    else $error("reentry without the halt request bit");

  chk_w1c_clear: assert property (
    (ce_i && st_wr && st_set == '0) |=> (s.status == ($past(s.status) & ~$past(dbg_wdata_i[ST_WIDTH-1:0]))))
    else $error("status write did not clear exactly the ones");

  chk_halt_flag_set: assert property (
    (ce_i && halt_req_ev && !local_reset_i) |=> s.status[ST_HALT] && halted_o)
    else $error("halt request did not set the halt flag");

  chk_key_refused: assert property (
    (ce_i && wr && dbg_addr_i == ADDR_HALT_CONTROL && dbg_wdata_i[31:KEY_LSB] != WRITE_UNLOCK_KEY)
      |=> ($stable(s.debug_en) && $stable(s.step) && $stable(s.maskints)))
    else $error("halt control write without the key took effect");

  chk_local_keeps: assert property (
    (ce_i && local_reset_i && !st_wr && st_set == '0) |=> (s.status == $past(s.status)))
    else $error("local reset changed the event status");

  chk_w0_keeps: assert property (
    (ce_i && st_wr) |=> ((s.status & $past(s.status & ~st_clr)) == $past(s.status & ~st_clr)))
    else $error("status flag cleared without a one written");

  chk_step_halts: assert property (
    (ce_i && s.debug_en && take_step && !local_reset_i) |=> (halted_o && s.status[ST_HALT]))
    else $error("step event did not halt");

  chk_one_sync: assert property (
    $onehot0({take_vc, take_breakpoint_event_flag, take_step}))
    else $error("more than one synchronous event taken");

  cov_vc_halt:   cover property (s.state == DVC_CATCH ##1 halted_o && s.status[ST_VECTOR_CATCH_FLAG]);
  cov_step_halt: cover property (s.state == DVC_STEP ##[1:20] (halted_o && s.status[ST_HALT]));
  cov_restart:   cover property (halted_o && restart_ev ##1 !halted_o);
  cov_ext_halt:  cover property (ext_ev && s.debug_en ##1 halted_o);
  cov_mon_breakpoint_event_flag:  cover property (mon_exc_req_o && take_breakpoint_event_flag);

endmodule

`default_nettype wire

//--- inc/dvc_pkg.sv
// Shared constants for the debug event and vector catch block.
// Assumes a 32-bit word-wide debug register port and one processor clock.
package dvc_pkg;

  // Register byte addresses on the debug register port.
  localparam logic [31:0] ADDR_EVENT_STATUS  = 32'he000ede0;
  localparam logic [31:0] ADDR_HALT_CONTROL  = 32'he000edf0;
  localparam logic [31:0] ADDR_CORE_SELECTOR = 32'he000edf4;
  localparam logic [31:0] ADDR_CORE_TRANSFER = 32'he000edf8;
  localparam logic [31:0] ADDR_MONITOR_CTL   = 32'he000edfc;
  localparam logic [31:0] ADDR_RESERVED_LO   = 32'he000ee00;
  localparam logic [31:0] ADDR_RESERVED_HI   = 32'he000eeff;

  // Halt control and status fields.
  localparam logic [15:0] WRITE_UNLOCK_KEY = 16'ha05f;
  localparam int          KEY_LSB          = 16;
  localparam int          HC_DEBUG_EN      = 0;
  localparam int          HC_HALT          = 1;
  localparam int          HC_STEP          = 2;
  localparam int          HC_MASKINTS      = 3;
  localparam int          HC_S_HALT        = 17;

  // Exception and monitor control fields.
  localparam int VC_LOW_BIT  = 0;
  localparam int VC_FIELD_LO = 4;
  localparam int VC_FIELD_HI = 10;
  localparam int VC_COUNT    = 8;
  localparam int MON_ENABLE  = 16;
  localparam int MON_PEND    = 17;
  localparam int MONITOR_STEP_ENABLE    = 18;

  // Debug event status flags.
  localparam int ST_WIDTH    = 5;
  localparam int ST_HALT     = 0;
  localparam int ST_BREAKPOINT_EVENT_FLAG     = 1;
  localparam int ST_WATCH    = 2;
  localparam int ST_VECTOR_CATCH_FLAG   = 3;
  localparam int ST_EXTERNAL = 4;
  localparam logic [ST_WIDTH-1:0] STATUS_RESET = 5'h00;

  // Gray codes along run, catch, halt, step.
  typedef enum logic [1:0] {
    DVC_RUN   = 2'b00,
    DVC_CATCH = 2'b01,
    DVC_HALT  = 2'b11,
    DVC_STEP  = 2'b10
  } dvc_state_t;

endpackage

//--- testbench/debug_event_vector_catch_tb.sv
// Self-checking bench for the debug event and vector catch block.
// Assumes the debugger model drives the register port; core events are driven here at falling edges.
`timescale 1ns/1ps
`default_nettype none

module debug_event_vector_catch_tb;
  import dvc_pkg::*;
  logic        clk, rst, lrst, req, wr, ack, iv, idone, bk, ff, ud, wm, mf;
  logic        et, ef, hf, ohr, ors, halted, exa, mema, sup, mon, pbm;
  logic [2:0]  idx;
  logic [7:0]  fc, fclr;
  logic [31:0] addr, wdata, rdata, d, xo, so;
  int          fails, comparisons, n;

  dvc_debugger_model i_dvc_debugger_model (.ref_clk_i(clk), .dbg_ack_i(ack), .dbg_rdata_i(rdata),
    .dbg_req_o(req), .dbg_write_o(wr), .dbg_addr_o(addr), .dbg_wdata_o(wdata));

  dvc_debug_event i_dvc_debug_event (.ref_clk_i(clk), .reset_i(rst), .ce_i(1'b1), .local_reset_i(lrst),
    .dbg_req_i(req), .dbg_write_i(wr), .dbg_addr_i(addr), .dbg_wdata_i(wdata), .dbg_ack_o(ack),
    .dbg_rdata_o(rdata), .instr_valid_i(iv), .instr_done_i(idone), .breakpoint_event_flag_match_i(bk),
    .fetch_fault_i(ff), .undef_instr_i(ud), .watch_match_i(wm), .mpu_fault_i(mf), .exc_taken_i(et),
    .exc_vc_idx_i(idx), .exc_fault_i(ef), .handler_first_i(hf), .prio_below_mon_i(pbm),
    .fault_clear_i(fclr), .outside_halt_request_i(ohr), .outside_restart_i(ors), .halted_o(halted),
    .exec_allow_o(exa), .mem_access_allow_o(mema), .sync_suppress_o(sup), .mon_exc_req_o(mon),
    .mask_ints_o(), .fault_cause_o(fc), .core_reg_sel_o(so), .core_sel_wr_o(), .core_reg_xfer_o(xo));

  always #12.5 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] v);
    i_dvc_debugger_model.access(1'b1, a, v, d);
  endtask

  task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    i_dvc_debugger_model.access(1'b0, a, 32'h0, d);
    chk({name, "_ack"}, {31'h0, i_dvc_debugger_model.ack_seen}, 32'h1);
    chk(name, d, exp);
  endtask

  task automatic halt_is(input string name, input logic e);
    int k;
    for (k = 0; k < 6 && halted !== e; k++) @(negedge clk);
    chk(name, {31'h0, halted}, {31'h0, e});
  endtask

  task automatic cyc();
    @(negedge clk);
  endtask

  task automatic resume();
    i_dvc_debugger_model.halt_ctl(16'h0001);
    wreg(ADDR_EVENT_STATUS, 32'h1f);
    halt_is("resume", 1'b0);
  endtask

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end

  initial begin
    {clk, lrst, iv, idone, bk, ff, ud, wm, mf, et, ef, hf, ohr, ors, pbm, idx, fclr} = '0;
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    cyc();
    rst = 1'b0;
    rdchk("status_reset", ADDR_EVENT_STATUS, 32'h0);
    wreg(ADDR_HALT_CONTROL, 32'h0000_0003);
    halt_is("halt_no_key", 1'b0);
    i_dvc_debugger_model.halt_ctl(16'h0003);
    halt_is("halt_req", 1'b1);
    rdchk("status_halt", ADDR_EVENT_STATUS, 32'h1);
    i_dvc_debugger_model.access(1'b0, ADDR_HALT_CONTROL, 32'h0, d);
    chk("halt_and_halted", d & 32'h0002_0002, 32'h0002_0002);
    wreg(ADDR_EVENT_STATUS, 32'h0);
    rdchk("w0_keeps", ADDR_EVENT_STATUS, 32'h1);
    wreg(ADDR_EVENT_STATUS, 32'h1);
    rdchk("w1_clears", ADDR_EVENT_STATUS, 32'h0);
    resume();
    // A faulting fetch must not turn a breakpoint into an event.
    {iv, bk, ff} = 3'b111;
    #1 chk("breakpoint_event_flag_fault_sup", {31'h0, sup}, 32'h0);
    cyc();
    {iv, bk, ff} = 3'b000;
    halt_is("breakpoint_event_flag_fault", 1'b0);
    {iv, bk} = 2'b11;
    #1 chk("breakpoint_event_flag_exec", {30'h0, exa, sup}, 32'h1);
    cyc();
    {iv, bk} = 2'b00;
    halt_is("breakpoint_event_flag", 1'b1);
    rdchk("status_breakpoint_event_flag", ADDR_EVENT_STATUS, 32'h2);
    resume();
    {iv, wm, mf} = 3'b111;
    cyc();
    {iv, wm, mf} = 3'b000;
    halt_is("watch_mpu", 1'b0);
    {iv, wm, ud} = 3'b111;
    #1 chk("undef_mem", {31'h0, mema}, 32'h0);
    cyc();
    {iv, wm, ud} = 3'b000;
    halt_is("watch_undef", 1'b0);
    {iv, wm} = 2'b11;
    cyc();
    {iv, wm} = 2'b00;
    halt_is("watch", 1'b1);
    rdchk("status_watch", ADDR_EVENT_STATUS, 32'h4);
    resume();
    wreg(ADDR_MONITOR_CTL, 32'h0001_07f1);
    for (n = 0; n < 8; n++) begin
      // Clearing the causes first lets the late exception prove its own record.
      if (n == 7) begin
        fclr = 8'hff;
        cyc();
        fclr = 8'h00;
        chk("fault_clear", {24'h0, fc}, 32'h0);
      end
      {et, ef, idx} = {2'b11, 3'(n)};
      cyc();
      // The last pass adds a late exception so the halt moves to the final handler.
      if (n == 7) begin
        idx = 3'h1;
        cyc();
      end
      {et, ef} = 2'b00;
      chk("catch_no_mon", {31'h0, mon}, 32'h0);
      {iv, hf} = 2'b11;
      #1 chk("catch_exec", {31'h0, exa}, 32'h0);
      cyc();
      {iv, hf} = 2'b00;
      halt_is("catch", 1'b1);
      chk("fault_cause", {31'h0, fc[n]}, 32'h1);
      rdchk("status_catch", ADDR_EVENT_STATUS, 32'h8);
      resume();
    end
    chk("late_fault", {31'h0, fc[1]}, 32'h1);
    wreg(ADDR_MONITOR_CTL, 32'h0);
    {et, ef, idx} = 5'b11010;
    cyc();
    {et, ef} = 2'b00;
    {iv, hf} = 2'b11;
    cyc();
    {iv, hf} = 2'b00;
    halt_is("catch_off", 1'b0);
    ohr = 1'b1;
    halt_is("external", 1'b1);
    rdchk("status_ext", ADDR_EVENT_STATUS, 32'h10);
    ohr = 1'b0;
    ors = 1'b1;
    halt_is("restart", 1'b0);
    ors = 1'b0;
    lrst = 1'b1;
    cyc();
    lrst = 1'b0;
    rdchk("local_keeps", ADDR_EVENT_STATUS, 32'h10);
    // With halting debug off, a catch must neither halt nor raise the monitor exception.
    wreg(ADDR_EVENT_STATUS, 32'h1f);
    i_dvc_debugger_model.halt_ctl(16'h0000);
    wreg(ADDR_MONITOR_CTL, 32'h0001_07f1);
    pbm = 1'b1;
    {et, ef, idx} = 5'b11011;
    cyc();
    {et, ef} = 2'b00;
    {iv, hf} = 2'b11;
    #1 chk("catch_mon_off", {31'h0, mon}, 32'h0);
    cyc();
    {iv, hf} = 2'b00;
    halt_is("catch_no_halt", 1'b0);
    {iv, bk} = 2'b11;
    #1 chk("breakpoint_event_flag_mon", {31'h0, mon}, 32'h1);
    cyc();
    {iv, bk} = 2'b00;
    pbm = 1'b0;
    halt_is("breakpoint_event_flag_mon_run", 1'b0);
    rdchk("status_mon", ADDR_EVENT_STATUS, 32'h2);
    wreg(ADDR_MONITOR_CTL, 32'h0);
    wreg(ADDR_EVENT_STATUS, 32'h1f);
    i_dvc_debugger_model.halt_ctl(16'h0003);
    halt_is("pre_step", 1'b1);
    wreg(ADDR_EVENT_STATUS, 32'h1f);
    i_dvc_debugger_model.halt_ctl(16'h0005);
    halt_is("step_leave", 1'b0);
    iv = 1'b1;
    cyc();
    idone = 1'b1;
    cyc();
    idone = 1'b0;
    halt_is("step", 1'b1);
    iv = 1'b0;
    rdchk("status_step", ADDR_EVENT_STATUS, 32'h1);
    wreg(ADDR_CORE_TRANSFER, 32'ha5a5_f00f);
    chk("xfer_out", xo, 32'ha5a5_f00f);
    wreg(ADDR_CORE_SELECTOR, 32'h0001_0005);
    chk("sel_out", so, 32'h0001_0005);
    rdchk("sel_write_only", ADDR_CORE_SELECTOR, 32'h0);
    rdchk("xfer_32", ADDR_CORE_TRANSFER, 32'ha5a5_f00f);
    wreg(ADDR_RESERVED_LO, 32'hffff_ffff);
    rdchk("reserved_lo", ADDR_RESERVED_LO, 32'h0);
    rdchk("reserved_hi", ADDR_RESERVED_HI, 32'h0);
    rst = 1'b1;
    cyc();
    rst = 1'b0;
    rdchk("por_clears", ADDR_EVENT_STATUS, 32'h0);
    end_sim();
  end
endmodule

`default_nettype wire

//--- testbench/dvc_debugger_model.sv
// External debugger model that issues word accesses on the debug register port.
// Assumes one request cycle per access and an acknowledge one cycle later.
`timescale 1ns/1ps
`default_nettype none

module dvc_debugger_model (
  input  wire logic        ref_clk_i,
  input  wire logic        dbg_ack_i,
  input  wire logic [31:0] dbg_rdata_i,
  output logic             dbg_req_o,
  output logic             dbg_write_o,
  output logic [31:0]      dbg_addr_o,
  output logic [31:0]      dbg_wdata_o
);
  import dvc_pkg::*;
  logic ack_seen;

  initial begin
    dbg_req_o   = 1'b0;
    dbg_write_o = 1'b0;
    dbg_addr_o  = 32'h0;
    dbg_wdata_o = 32'h0;
    ack_seen    = 1'b0;
  end

  // Address and data are inverted when idle so a stale value is never mistaken for a live one.
  task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata);
    @(negedge ref_clk_i);
    dbg_req_o   = 1'b1;
    dbg_write_o = wr;
    dbg_addr_o  = addr;
    dbg_wdata_o = data;
    @(negedge ref_clk_i);
    dbg_req_o   = 1'b0;
    ack_seen    = dbg_ack_i;
    rdata       = dbg_rdata_i;
    dbg_write_o = 1'b0;
    dbg_addr_o  = ~addr;
    dbg_wdata_o = ~data;
  endtask

  // Halt control writes always carry the unlock key.
  task automatic halt_ctl(input logic [15:0] bits);
    logic [31:0] unused;
    access(1'b1, ADDR_HALT_CONTROL, {WRITE_UNLOCK_KEY, bits}, unused);
  endtask
endmodule

`default_nettype wire
